// >>> pkg/fsps_pkg.sv
// Shared constants and types of the flash self-program sequencer.
// Notes on behaviour
// - Flash is 30 erase pages of 512 bytes; page erase clears one page.
// - Erased bytes read FF; software erases a page before programming.
// - Whole-array erase and single-page erase are both supported.
// - Data port supplies program byte and holds the byte fetched by a read.
// - Address high and low registers form the target of every operation.
// - Selector 000 idle, 001 read, 010 program, 011 page erase.
// - Codes 111, 101, 110 erase, read, program option word two if addr bit0 set.
// - Operation starts only after 46h then B9h, with control bit 7 set.
// - Reading the command port gives an identifier byte chosen by addr bit0.
// - Change enable one permits program and erase; zero blocks them.
// - Boot select picks entry after soft reset: 0 application, 1 boot area.
// - Writing one to soft reset bit resets the system; bit self-clears.
// - Soft reset keeps change enable and boot select; power-up clears them.
// - Wait code sets erase, program and read stall lengths in machine cycles.
// - CPU is held for the wait; read data is ready when it resumes.
// - Software loads selector, control, address, then the command pair.
// - Power-up boots boot area if fuse is 0 and size bits not both one.
// - Application code cannot change boot memory; such attempts are ignored.
// - Data area is at most 6K and exists only when option bits 5:4 are 10.
package fsps_pkg;

    // Flash geometry
    localparam int          FSPS_PAGES        = 30;
    localparam int          FSPS_PAGE_BYTES   = 512;
    localparam logic [7:0]  FSPS_ERASED_BYTE  = 8'hFF;
    localparam logic [7:0]  FSPS_RESET_BYTE   = 8'h00;

    // Register byte offsets on the bus
    localparam logic [4:0]  FSPS_OFS_DATA     = 5'h00;
    localparam logic [4:0]  FSPS_OFS_ADDR_HI  = 5'h04;
    localparam logic [4:0]  FSPS_OFS_ADDR_LO  = 5'h08;
    localparam logic [4:0]  FSPS_OFS_OP_SEL   = 5'h0C;
    localparam logic [4:0]  FSPS_OFS_CMD      = 5'h10;
    localparam logic [4:0]  FSPS_OFS_CONTROL  = 5'h14;
    localparam logic [4:0]  FSPS_OFS_STATUS   = 5'h18;

    // Control register fields
    localparam int          FSPS_CTL_EN_BIT   = 7;
    localparam int          FSPS_CTL_BOOT_BIT = 6;
    localparam int          FSPS_CTL_SRST_BIT = 5;
    localparam int          FSPS_CTL_WAIT_LSB = 0;
    localparam int          FSPS_WAIT_W       = 3;

    // Status register fields
    localparam int          FSPS_STA_BUSY_BIT = 0;
    localparam int          FSPS_STA_BOOT_BIT = 1;
    localparam int          FSPS_STA_DATA_BIT = 2;

    // Unlock command bytes
    localparam logic [7:0]  FSPS_CMD_FIRST    = 8'h46;
    localparam logic [7:0]  FSPS_CMD_SECOND   = 8'hB9;

    // Data area: key in first option word bits 5:4, size in bytes
    localparam int          FSPS_OPT_KEY_LSB  = 4;
    localparam logic [1:0]  FSPS_DATA_KEY     = 2'b10;
    localparam int          FSPS_DATA_BYTES   = 6144;
    localparam logic [15:0] FSPS_DATA_BASE    = 16'h2000;

    // Machine cycle length and stall table, indexed by wait code
    localparam int          FSPS_CLKS_PER_MC  = 12;
    localparam int          FSPS_WAIT_CODES   = 4;
    localparam int          FSPS_ERASE_MC [FSPS_WAIT_CODES] =
        '{43769, 21885, 10942, 5471};
    localparam int          FSPS_PROG_MC  [FSPS_WAIT_CODES] =
        '{240, 120, 60, 30};
    localparam int          FSPS_READ_MC  [FSPS_WAIT_CODES] =
        '{43, 22, 11, 6};
    localparam int          FSPS_CNT_W        = 20;

    // Operation selector codes
    typedef enum logic [2:0] {
        FSPS_OP_STANDBY   = 3'b000,
        FSPS_OP_READ      = 3'b001,
        FSPS_OP_PROG      = 3'b010,
        FSPS_OP_ERASE     = 3'b011,
        FSPS_OP_RSVD      = 3'b100,
        FSPS_OP_OPT_READ  = 3'b101,
        FSPS_OP_OPT_PROG  = 3'b110,
        FSPS_OP_OPT_ERASE = 3'b111
    } fsps_op_t;

    // Unlock detector states
    typedef enum logic [0:0] {
        FSPS_UL_IDLE  = 1'b0,
        FSPS_UL_ARMED = 1'b1
    } fsps_unlock_t;

endpackage

// >>> verilog/fsps_flash_array.sv
// Embedded flash storage and second option word, flip-flop model.
`timescale 1ns/1ps
module fsps_flash_array
    import fsps_pkg::*;
#(
    parameter int PAGES      = FSPS_PAGES,
    parameter int PAGE_BYTES = FSPS_PAGE_BYTES
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [15:0] addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        prog_in,
    input  wire logic        erase_page_in,
    input  wire logic        mass_erase_in,
    input  wire logic        opt_prog_in,
    input  wire logic        opt_erase_in,
    output logic      [7:0]  rdata_out,
    output logic      [7:0]  opt_rdata_out
);
    localparam int DEPTH = PAGES * PAGE_BYTES;

    if (DEPTH > 65536 || PAGES < 1 || PAGE_BYTES < 1) begin : g_bad_size
        $error("flash array does not fit a 16-bit address");
    end

    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
        logic [7:0]            opt;
    } fsps_array_t;

    fsps_array_t s_q;
    fsps_array_t s_d;

    // Programming only clears bits, hence erase must come first
    always_comb begin
        s_d = s_q;
        for (int i = 0; i < DEPTH; i++) begin
            if (mass_erase_in ||
                (erase_page_in &&
                 (i / PAGE_BYTES) == (int'(addr_in) / PAGE_BYTES))) begin
                s_d.mem[i] = FSPS_ERASED_BYTE;
            end else if (prog_in && i == int'(addr_in)) begin
                s_d.mem[i] = s_q.mem[i] & wdata_in;
            end
        end
        if (opt_erase_in) begin
            s_d.opt = FSPS_ERASED_BYTE;
        end else if (opt_prog_in) begin
            s_d.opt = s_q.opt & wdata_in;
        end
    end

    // Reset stands in for the factory-erased state; soft reset never reaches here
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_q <= {(DEPTH + 1){FSPS_ERASED_BYTE}};
        end else begin
            s_q <= s_d;
        end
    end

    // Out-of-range addresses read as erased
    assign rdata_out     = (int'(addr_in) < DEPTH) ?
                           s_q.mem[addr_in] : FSPS_ERASED_BYTE;
    assign opt_rdata_out = s_q.opt;

endmodule

// >>> verilog/fsps_sequencer.sv
// Flash self-program sequencer: bus registers, unlock, stall and boot choice.
//
// Our own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module fsps_sequencer
    import fsps_pkg::*;
#(
    parameter int          PAGES       = FSPS_PAGES,
    parameter int          PAGE_BYTES  = FSPS_PAGE_BYTES,
    parameter int          CLKS_PER_MC = FSPS_CLKS_PER_MC,
    parameter logic [15:0] DATA_BASE   = FSPS_DATA_BASE,
    parameter logic [7:0]  ID_HIGH     = 8'hA5,   // Arbitrary value
    parameter logic [7:0]  ID_LOW      = 8'h5A    // Arbitrary value
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Boot straps and option word from the fuse block
    input  wire logic        hardware_boot_fuse_in,
    input  wire logic        boot_area_size_hi_in,
    input  wire logic        boot_area_size_lo_in,
    input  wire logic [7:0]  first_option_word_in,
    // External programmer whole-array erase request
    input  wire logic        mass_erase_in,
    // System side
    output logic             cpu_hold_out,
    output logic             soft_reset_out,
    output logic             boot_from_boot_area_out
);
    localparam int DEPTH = PAGES * PAGE_BYTES;

    if (DEPTH > 65536 || CLKS_PER_MC < 1 ||
        FSPS_ERASE_MC[0] * CLKS_PER_MC >= (1 << FSPS_CNT_W) ||
        int'(DATA_BASE) + FSPS_DATA_BYTES > DEPTH) begin : g_bad_param
        $error("sequencer parameters out of range");
    end

    // Whole state of the sequencer
    typedef struct packed {
        logic [7:0]             data;
        logic [7:0]             addr_hi;
        logic [7:0]             addr_lo;
        logic [7:0]             op_sel;
        logic                   change_en;
        logic                   boot_sel;
        logic [FSPS_WAIT_W-1:0] wait_code;
        fsps_unlock_t           unlock;
        logic                   busy;
        logic [FSPS_CNT_W-1:0]  count;
        fsps_op_t               op;
        logic                   boot_from;
        logic                   boot_pending;
        logic                   soft_rst;
    } fsps_state_t;

    localparam fsps_state_t STATE_RESET = '{
        data:         FSPS_RESET_BYTE,
        addr_hi:      FSPS_RESET_BYTE,
        addr_lo:      FSPS_RESET_BYTE,
        op_sel:       FSPS_RESET_BYTE,
        change_en:    1'b0,
        boot_sel:     1'b0,
        wait_code:    3'h0,
        unlock:       FSPS_UL_IDLE,
        busy:         1'b0,
        count:        20'h00000,
        op:           FSPS_OP_STANDBY,
        boot_from:    1'b0,
        boot_pending: 1'b1,
        soft_rst:     1'b0
    };

    fsps_state_t s_q;
    fsps_state_t s_d;

    logic [15:0] target;
    logic [7:0]  flash_rdata;
    logic [7:0]  opt_rdata;
    logic        data_area_on;
    logic        in_data_area;
    logic        may_change;
    logic        bus_wr;
    logic        bus_rd;
    logic        start;
    fsps_op_t    start_op;
    logic        op_valid;
    logic        go_prog;
    logic        go_erase;
    logic        go_opt_prog;
    logic        go_opt_erase;
    logic [1:0]  wait_idx;
    int          load_mc;

    // Target address from the two address registers
    assign target = {s_q.addr_hi, s_q.addr_lo};

    // Accesses complete only while idle; the stall is the CPU hold
    assign avs_waitrequest = s_q.busy;
    assign bus_wr = avs_write && !s_q.busy && avs_byteenable[0];
    assign bus_rd = avs_read && !s_q.busy;

    // Data area exists only with the option key, never beyond 6K
    assign data_area_on = first_option_word_in[FSPS_OPT_KEY_LSB +: 2]
                          == FSPS_DATA_KEY;
    assign in_data_area = data_area_on && target >= DATA_BASE &&
                          int'(target) < int'(DATA_BASE) + FSPS_DATA_BYTES;

    // Boot code may change all of the array, application code only data area
    assign may_change = s_q.boot_from ? (int'(target) < DEPTH)
                                      : in_data_area;

    // Unlock pair completes on a matching second byte with enable set
    assign start = bus_wr && avs_address == FSPS_OFS_CMD &&
                   s_q.unlock == FSPS_UL_ARMED &&
                   avs_writedata[7:0] == FSPS_CMD_SECOND &&
                   s_q.change_en;
    assign start_op = fsps_op_t'(s_q.op_sel[2:0]);

    // Which codes run; option word codes need address bit 0 set
    always_comb begin
        unique case (start_op)
            FSPS_OP_READ,
            FSPS_OP_PROG,
            FSPS_OP_ERASE:     op_valid = 1'b1;
            FSPS_OP_OPT_READ,
            FSPS_OP_OPT_PROG,
            FSPS_OP_OPT_ERASE: op_valid = s_q.addr_lo[0];
            FSPS_OP_STANDBY,
            FSPS_OP_RSVD:      op_valid = 1'b0;
        endcase
    end

    // Change strobes; a protected target still stalls but changes nothing
    assign go_prog      = start && op_valid && start_op == FSPS_OP_PROG &&
                          may_change && s_q.change_en;
    assign go_erase     = start && op_valid && start_op == FSPS_OP_ERASE &&
                          may_change && s_q.change_en;
    assign go_opt_prog  = start && op_valid &&
                          start_op == FSPS_OP_OPT_PROG && s_q.change_en;
    assign go_opt_erase = start && op_valid &&
                          start_op == FSPS_OP_OPT_ERASE && s_q.change_en;

    // Codes above 011 are undefined; the longest wait is the safe choice
    assign wait_idx = s_q.wait_code[2] ? 2'b00 : s_q.wait_code[1:0];

    // Stall length in machine cycles for the starting operation
    always_comb begin
        unique case (start_op)
            FSPS_OP_ERASE,
            FSPS_OP_OPT_ERASE: load_mc = FSPS_ERASE_MC[wait_idx];
            FSPS_OP_PROG,
            FSPS_OP_OPT_PROG:  load_mc = FSPS_PROG_MC[wait_idx];
            default:           load_mc = FSPS_READ_MC[wait_idx];
        endcase
    end

    // Next state
    always_comb begin
        s_d = s_q;
        s_d.soft_rst = 1'b0;

        // First edge after power-up: choose entry from fuse and size bits
        if (s_q.boot_pending) begin
            s_d.boot_pending = 1'b0;
            s_d.boot_from = !hardware_boot_fuse_in &&
                            !(boot_area_size_hi_in &&
                              boot_area_size_lo_in);
        end

        // Stall countdown; read byte lands on the same edge that releases the CPU
        if (s_q.busy) begin
            if (s_q.count == '0) begin
                s_d.busy = 1'b0;
                if (s_q.op == FSPS_OP_READ) begin
                    s_d.data = flash_rdata;
                end else if (s_q.op == FSPS_OP_OPT_READ) begin
                    s_d.data = opt_rdata;
                end
            end else begin
                s_d.count = s_q.count - 1'b1;
            end
        end

        // Register writes
        if (bus_wr) begin
            unique case (avs_address)
                FSPS_OFS_DATA:    s_d.data    = avs_writedata[7:0];
                FSPS_OFS_ADDR_HI: s_d.addr_hi = avs_writedata[7:0];
                FSPS_OFS_ADDR_LO: s_d.addr_lo = avs_writedata[7:0];
                FSPS_OFS_OP_SEL:  s_d.op_sel  = avs_writedata[7:0];
                FSPS_OFS_CMD: begin
                    // Any byte but the expected one drops back to idle
                    if (s_q.unlock == FSPS_UL_IDLE) begin
                        if (avs_writedata[7:0] == FSPS_CMD_FIRST) begin
                            s_d.unlock = FSPS_UL_ARMED;
                        end
                    end else begin
                        s_d.unlock = FSPS_UL_IDLE;
                    end
                end
                FSPS_OFS_CONTROL: begin
                    s_d.change_en = avs_writedata[FSPS_CTL_EN_BIT];
                    s_d.boot_sel  = avs_writedata[FSPS_CTL_BOOT_BIT];
                    s_d.wait_code =
                        avs_writedata[FSPS_CTL_WAIT_LSB +: FSPS_WAIT_W];
                    if (avs_writedata[FSPS_CTL_SRST_BIT]) begin
                        // Soft reset keeps enable and boot select only
                        s_d.data      = FSPS_RESET_BYTE;
                        s_d.addr_hi   = FSPS_RESET_BYTE;
                        s_d.addr_lo   = FSPS_RESET_BYTE;
                        s_d.op_sel    = FSPS_RESET_BYTE;
                        s_d.wait_code = 3'h0;
                        s_d.unlock    = FSPS_UL_IDLE;
                        s_d.soft_rst  = 1'b1;
                        s_d.boot_from =
                            avs_writedata[FSPS_CTL_BOOT_BIT];
                    end
                end
                default: begin
                end
            endcase
        end

        // Launch: hold the CPU for the selected number of clocks
        if (start && op_valid) begin
            s_d.busy  = 1'b1;
            s_d.op    = start_op;
            s_d.count = FSPS_CNT_W'(load_mc * CLKS_PER_MC - 1);
        end
    end

    // State register; power-up is the only reset that clears enable bits
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_q <= STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Register read mux; reserved bits read zero, trigger bit reads zero
    always_comb begin
        avs_readdata = 32'h00000000;
        if (bus_rd) begin
            unique case (avs_address)
                FSPS_OFS_DATA:    avs_readdata[7:0] = s_q.data;
                FSPS_OFS_ADDR_HI: avs_readdata[7:0] = s_q.addr_hi;
                FSPS_OFS_ADDR_LO: avs_readdata[7:0] = s_q.addr_lo;
                FSPS_OFS_OP_SEL:  avs_readdata[7:0] = s_q.op_sel;
                FSPS_OFS_CMD:     avs_readdata[7:0] =
                    s_q.addr_lo[0] ? ID_HIGH : ID_LOW;
                FSPS_OFS_CONTROL: begin
                    avs_readdata[FSPS_CTL_EN_BIT]   = s_q.change_en;
                    avs_readdata[FSPS_CTL_BOOT_BIT] = s_q.boot_sel;
                    avs_readdata[FSPS_CTL_WAIT_LSB +: FSPS_WAIT_W] =
                        s_q.wait_code;
                end
                FSPS_OFS_STATUS: begin
                    avs_readdata[FSPS_STA_BUSY_BIT] = s_q.busy;
                    avs_readdata[FSPS_STA_BOOT_BIT] = s_q.boot_from;
                    avs_readdata[FSPS_STA_DATA_BIT] = data_area_on;
                end
                default: begin
                end
            endcase
        end
    end

    // Storage; first option word is an input only and has no write path
    fsps_flash_array #(
        .PAGES      (PAGES),
        .PAGE_BYTES (PAGE_BYTES)
    ) u_array (
        .clk_in        (clk_in),
        .rst_in        (rst_in),
        .addr_in       (target),
        .wdata_in      (s_q.data),
        .prog_in       (go_prog),
        .erase_page_in (go_erase),
        .mass_erase_in (mass_erase_in),
        .opt_prog_in   (go_opt_prog),
        .opt_erase_in  (go_opt_erase),
        .rdata_out     (flash_rdata),
        .opt_rdata_out (opt_rdata)
    );

    // System outputs, all straight from flip-flops
    assign cpu_hold_out            = s_q.busy;
    assign soft_reset_out          = s_q.soft_rst;
    assign boot_from_boot_area_out = s_q.boot_from;

endmodule

// >>> sim/fsps_monitor.sv
// Concurrent checks on the sequencer's bus, stall and reset outputs.
`timescale 1ns/1ps
module fsps_monitor
    import fsps_pkg::*;
#(
    parameter int CLKS_PER_MC = FSPS_CLKS_PER_MC
) (
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        cpu_hold_out,
    input wire logic        soft_reset_out,
    input wire logic        boot_from_boot_area_out
);
    localparam int MAX_STALL = FSPS_ERASE_MC[0] * CLKS_PER_MC;
    logic [20:0] busy_q;

    // Length of the running stall; too long to unroll in a property
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            busy_q <= '0;
        end else begin
            busy_q <= avs_waitrequest ? busy_q + 21'h1 : '0;
        end
    end

    default clocking mon_cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    // Stall, bus and reset relations
    a_hold_tracks_wait: assert property (
        cpu_hold_out == avs_waitrequest)
        else $error("cpu hold differs from waitrequest");
    a_idle_read_zero: assert property (
        (!avs_read || avs_waitrequest) |-> avs_readdata == 32'h0)
        else $error("readdata not zero");
    a_upper_bytes_zero: assert property (
        avs_readdata[31:8] == 24'h0)
        else $error("readdata upper bytes set");
    a_srst_one_cycle: assert property (
        soft_reset_out |=> !soft_reset_out)
        else $error("soft reset longer than one cycle");
    a_srst_has_cause: assert property (
        soft_reset_out |-> $past(avs_write && !avs_waitrequest &&
        avs_byteenable[0] && avs_writedata[FSPS_CTL_SRST_BIT] &&
        avs_address == FSPS_OFS_CONTROL))
        else $error("stray soft reset");
    a_stall_after_unlock: assert property (
        $rose(avs_waitrequest) |-> $past(avs_write &&
        avs_address == FSPS_OFS_CMD &&
        avs_writedata[7:0] == FSPS_CMD_SECOND))
        else $error("stray stall");
    a_stall_min_len: assert property (
        $rose(avs_waitrequest) |-> avs_waitrequest[*6])
        else $error("stall too short");
    a_stall_bounded: assert property (
        busy_q <= MAX_STALL)
        else $error("stall too long");
    // Power-up choice lands one edge after release, seen one edge later
    a_boot_on_reset: assert property (
        $changed(boot_from_boot_area_out) |-> $past(rst_in, 2) ||
        soft_reset_out || $past(soft_reset_out))
        else $error("boot choice changed without reset");
endmodule

bind fsps_sequencer fsps_monitor #(.CLKS_PER_MC(CLKS_PER_MC)) fsps_monitor_inst (
    .clk_in(clk_in), .rst_in(rst_in), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cpu_hold_out(cpu_hold_out), .soft_reset_out(soft_reset_out),
    .boot_from_boot_area_out(boot_from_boot_area_out)
);

// >>> sim/test_flash_self_program_sequencer.sv
// Self-checking bench of the flash self-program sequencer.
`timescale 1ns/1ps
module test_flash_self_program_sequencer
    import fsps_pkg::*;
;
    localparam int         CPM   = 1;     // Short machine cycle keeps erase brief
    localparam logic [7:0] ID_HI = 8'hC3; // Arbitrary value
    localparam logic [7:0] ID_LO = 8'h3C; // Arbitrary value
    logic        clk_in, rst_in, avs_waitrequest, hold, srst, boot;
    logic        avs_read = 1'b0, avs_write = 1'b0, mass = 1'b0;
    logic        fuse = 1'b0, size_hi = 1'b0, size_lo = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic [7:0]  opt0 = 8'h20;            // Data area key present
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    int          n_errors = 0, n_compared = 0, n_busy = 0, n_hold = 0;
    int          n_cyc = 0, n_srst = 0;

    fsps_sequencer #(.CLKS_PER_MC(CPM), .ID_HIGH(ID_HI), .ID_LOW(ID_LO))
    fsps_sequencer_inst (
        .clk_in(clk_in), .rst_in(rst_in), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .hardware_boot_fuse_in(fuse), .boot_area_size_hi_in(size_hi),
        .boot_area_size_lo_in(size_lo), .first_option_word_in(opt0),
        .mass_erase_in(mass), .cpu_hold_out(hold), .soft_reset_out(srst),
        .boot_from_boot_area_out(boot));

    // 250 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    // Stall and pulse counting, hang limit
    always @(posedge clk_in) begin
        n_cyc++;
        if (avs_waitrequest === 1'b1) n_busy++;
        if (hold === 1'b1) n_hold++;
        if (srst === 1'b1) n_srst++;
        if (n_cyc > 60000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (n_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One bus cycle, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_in);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clk_in); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic power_up(input logic f, h, l, exp);
        rst_in <= 1'b1;
        fuse <= f;
        size_hi <= h;
        size_lo <= l;
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        chk({31'h0, boot}, {31'h0, exp});
    endtask

    // Full operation; the data port read waits out the stall
    task automatic op(input logic [2:0] c, input logic [15:0] a,
                      input logic [7:0] d, ctl, input int st,
                      input logic [7:0] ex);
        logic [31:0] q;
        wr(FSPS_OFS_DATA, d);
        wr(FSPS_OFS_OP_SEL, {5'h00, c});
        wr(FSPS_OFS_CONTROL, ctl);
        wr(FSPS_OFS_ADDR_HI, a[15:8]);
        wr(FSPS_OFS_ADDR_LO, a[7:0]);
        wr(FSPS_OFS_CMD, FSPS_CMD_FIRST);
        n_busy = 0;
        n_hold = 0;
        wr(FSPS_OFS_CMD, FSPS_CMD_SECOND);
        bus(1'b0, FSPS_OFS_DATA, 8'h00, q);
        chk(n_busy, st);
        chk(n_hold, st);
        chk(q, {24'h0, ex});
    endtask

    initial begin
        logic [31:0] q;
        power_up(1'b0, 1'b1, 1'b1, 1'b0);
        power_up(1'b1, 1'b0, 1'b0, 1'b0);
        power_up(1'b0, 1'b0, 1'b0, 1'b1);
        // Identifier bytes, status and an unmapped offset
        wr(FSPS_OFS_ADDR_LO, 8'h01);
        bus(1'b0, FSPS_OFS_CMD, 8'h00, q);
        chk(q, {24'h0, ID_HI});
        wr(FSPS_OFS_ADDR_LO, 8'h00);
        bus(1'b0, FSPS_OFS_CMD, 8'h00, q);
        chk(q, {24'h0, ID_LO});
        bus(1'b0, FSPS_OFS_STATUS, 8'h00, q);
        chk(q, 32'h6);
        bus(1'b0, 5'h1C, 8'h00, q);
        chk(q, 32'h0);
        // Read stall for every wait code; 1xx takes the longest
        for (int i = 0; i < FSPS_WAIT_CODES; i++) begin
            op(FSPS_OP_READ, 16'h0040, 8'h00, 8'h80 | 8'(i),
               FSPS_READ_MC[i] * CPM, 8'hFF);
        end
        op(FSPS_OP_READ, 16'h0040, 8'h00, 8'h84, FSPS_READ_MC[0] * CPM,
           8'hFF);
        // Idle and reserved codes start nothing
        op(FSPS_OP_STANDBY, 16'h0040, 8'h77, 8'h83, 0,
           8'h77);
        op(FSPS_OP_RSVD, 16'h0040, 8'h66, 8'h83, 0, 8'h66);
        // Program both sides of a page edge, erase the lower page
        op(FSPS_OP_PROG, 16'h01FF, 8'h3C, 8'h83, FSPS_PROG_MC[3] * CPM, 8'h3C);
        op(FSPS_OP_PROG, 16'h0200, 8'h5A, 8'h83, FSPS_PROG_MC[3] * CPM, 8'h5A);
        op(FSPS_OP_ERASE, 16'h01FF, 8'h00, 8'h83, FSPS_ERASE_MC[3] * CPM,
           8'h00);
        op(FSPS_OP_READ, 16'h01FF, 8'h00, 8'h83, 6 * CPM,
           8'hFF);
        op(FSPS_OP_READ, 16'h0200, 8'h00, 8'h83, 6 * CPM,
           8'h5A);
        // Whole-array erase pulse
        @(posedge clk_in);
        mass <= 1'b1;
        @(posedge clk_in);
        mass <= 1'b0;
        op(FSPS_OP_READ, 16'h0200, 8'h00, 8'h83, 6 * CPM,
           8'hFF);
        // Change enable off, then a broken unlock pair
        op(FSPS_OP_PROG, 16'h0300, 8'h12, 8'h03, 0, 8'h12);
        op(FSPS_OP_READ, 16'h0300, 8'h00, 8'h83, 6 * CPM,
           8'hFF);
        wr(FSPS_OFS_CMD, FSPS_CMD_FIRST);
        wr(FSPS_OFS_CMD, 8'h47);
        n_busy = 0;
        wr(FSPS_OFS_CMD, FSPS_CMD_SECOND);
        bus(1'b0, FSPS_OFS_DATA, 8'h00, q);
        chk(n_busy, 0);
        // Second option word: address bit 0 gate, program, erase
        op(FSPS_OP_OPT_READ, 16'h0000, 8'h00, 8'h83, 0,
           8'h00);
        op(FSPS_OP_OPT_PROG, 16'h0001, 8'h0F, 8'h83, 30 * CPM, 8'h0F);
        op(FSPS_OP_OPT_READ, 16'h0001, 8'h00, 8'h83, 6 * CPM,
           8'h0F);
        op(FSPS_OP_OPT_ERASE, 16'h0001, 8'h00, 8'h83, FSPS_ERASE_MC[3] * CPM,
           8'h00);
        op(FSPS_OP_OPT_READ, 16'h0001, 8'h00, 8'h83, 6 * CPM,
           8'hFF);
        // Soft reset keeps enable and boot select, then leave to application
        wr(FSPS_OFS_CONTROL, 8'hE3);
        bus(1'b0, FSPS_OFS_CONTROL, 8'h00, q);
        chk(q, 32'h000000C0);
        chk({31'h0, boot}, 32'h1);
        wr(FSPS_OFS_CONTROL, 8'h20);
        bus(1'b0, FSPS_OFS_CONTROL, 8'h00, q);
        chk(q, 32'h0);
        chk({31'h0, boot}, 32'h0);
        // Application may change the data area only
        op(FSPS_OP_PROG, 16'h0100, 8'h00, 8'h83, FSPS_PROG_MC[3] * CPM, 8'h00);
        op(FSPS_OP_READ, 16'h0100, 8'h00, 8'h83, 6 * CPM,
           8'hFF);
        op(FSPS_OP_PROG, FSPS_DATA_BASE, 8'hA5, 8'h83, 30 * CPM, 8'hA5);
        op(FSPS_OP_READ, FSPS_DATA_BASE, 8'h00, 8'h83, 6 * CPM,
           8'hA5);
        chk(n_srst, 2);
        end_sim();
    end
endmodule
